// file: pbum_pkg.sv
// Shared types and constants for the port B upper pin multiplexer.
// Assumes one clock, clk_sys, and a synchronous active-low reset.
package pbum_pkg;

    // Pin index within the six-bit slice: index 0 is port B bit 26
    localparam int PBUM_NPINS = 6;
    localparam int IDX_B26    = 0;
    localparam int IDX_B27    = 1;
    localparam int IDX_B28    = 2;
    localparam int IDX_B29    = 3;
    localparam int IDX_B30    = 4;
    localparam int IDX_B31    = 5;

    localparam int PBUM_FIFO_DEPTH = 4;

    // Function selected on one pin; meaning depends on the pin
    typedef enum logic [2:0] {
        FN_OFF       = 3'h0, // Pin idle, buffer in input mode
        FN_FCC_MII   = 3'h1, // Fast controller, MII signal
        FN_FCC_HDLC  = 3'h2, // Fast controller RTS, HDLC or transparent
        FN_SCC       = 3'h3, // Second serial controller
        FN_TDM       = 3'h4  // Serial interface 2, channel B2 or C2
    } pbum_fn_t;

    typedef struct packed {
        pbum_fn_t b31;
        pbum_fn_t b30;
        pbum_fn_t b29;
        pbum_fn_t b28;
        pbum_fn_t b27;
        pbum_fn_t b26;
    } pbum_sel_t;

    // One transmit word, taken from the FIFO per transmit tick
    typedef struct packed {
        logic mii_tx_er;
        logic mii_tx_en;
        logic scc_txd;
        logic l1_txd_b;
        logic l1_txd_c;
    } pbum_tx_t;

    localparam int PBUM_TX_W = $bits(pbum_tx_t);

    // Inputs handed to the peripherals, forced idle when unselected
    typedef struct packed {
        logic scc_rxd;
        logic mii_rx_dv;
        logic mii_rx_er;
        logic mii_col;
        logic mii_crs;
        logic l1_rxd_b;
        logic l1_rsync_b;
        logic l1_tsync_b;
        logic l1_rxd_c;
    } pbum_rx_t;

    // Idle levels: serial lines rest at mark, MII strobes low
    localparam logic     IDLE_SERIAL = 1'h1;
    localparam logic     IDLE_STROBE = 1'h0;
    localparam logic     RTS_IDLE_N  = 1'h1;
    localparam pbum_tx_t TX_IDLE     = '{mii_tx_er: 1'h0, mii_tx_en: 1'h0,
                                         scc_txd: 1'h1, l1_txd_b: 1'h1,
                                         l1_txd_c: 1'h1};
    localparam pbum_rx_t RX_IDLE     = '{scc_rxd: 1'h1, mii_rx_dv: 1'h0,
                                         mii_rx_er: 1'h0, mii_col: 1'h0,
                                         mii_crs: 1'h0, l1_rxd_b: 1'h1,
                                         l1_rsync_b: 1'h0, l1_tsync_b: 1'h0,
                                         l1_rxd_c: 1'h1};

    // Request-to-send handshake states
    typedef enum logic [1:0] {
        RS_IDLE  = 2'h0,
        RS_REQ   = 2'h1,
        RS_GRANT = 2'h2
    } pbum_rts_st_t;

    localparam int RTS_FCC = 0;
    localparam int RTS_SCC = 1;

endpackage

// file: pbum_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; one clock, synchronous reset.
`timescale 1ns/1ns
module pbum_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0]    cnt_q, cnt_d;
    logic             push, pop;
    logic             ready_q, ready_d;

    // Ready is registered so the top's ready output comes from a flop
    assign in_ready  = ready_q;
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_d  = push ? wr_q + AW'(1) : wr_q;
        rd_d  = pop ? rd_q + AW'(1) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + CW'(1);
        end else if (pop && !push) begin
            cnt_d = cnt_q - CW'(1);
        end
        ready_d = (cnt_d != CW'(DEPTH));
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            ready_q <= 1'h1;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            ready_q <= ready_d;
        end
    end

    // Storage needs no reset; count guards every read
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

endmodule

// file: pbum_pad.sv
// One pin buffer: registered drive value, enable and input sample.
// Assumes the pin input is synchronous to clk_sys.
`timescale 1ns/1ns
module pbum_pad (
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic drive_en,
    input  wire logic drive_val,
    input  wire logic pin_in,
    output logic      pin_out,
    output logic      pin_oe_n,
    output logic      pin_val
);
    logic out_q, out_d, oe_n_q, oe_n_d, in_q, in_d;

    always_comb begin
        out_d  = drive_en ? drive_val : 1'h0;
        oe_n_d = !drive_en;
        in_d   = pin_in;
    end

    // Reset leaves the buffer in input mode
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            out_q  <= 1'h0;
            oe_n_q <= 1'h1;
            in_q   <= 1'h0;
        end else begin
            out_q  <= out_d;
            oe_n_q <= oe_n_d;
            in_q   <= in_d;
        end
    end

    assign pin_out  = out_q;
    assign pin_oe_n = oe_n_q;
    assign pin_val  = in_q;

endmodule

// file: pbum_top.sv
// Pin multiplexer for port B bits 31 down to 26.
// Assumes selections change only while the affected peripherals idle.
//
// What this block does
// - Bit 31: MII TX_ER, serial rxd, B2 txd
// - Drive TX_ER to force a medium error
// - Bit 30: serial txd, MII RX_DV, B2 rxd
// - Carrier without RX_DV means broken header
// - Bit 29: MII TX_EN or B2 receive sync
// - TX_EN high while transmit data is driven
// - Bit 28: RTS, RX_ER, RTS/SCC_ETHERNET_TX_ENABLE, B2 sync
// - Fast controller RTS low, CTS low grants
// - Serial RTS low, CTS grants; SCC_ETHERNET_TX_ENABLE in Ethernet
// - Bit 27: MII collision input or C2 txd
// - Bit 26: MII carrier input or C2 rxd
// - Channels B2, C2 carry single serial streams
`timescale 1ns/1ns
module pbum_top
    import pbum_pkg::*;
#(
    parameter int FIFO_DEPTH = PBUM_FIFO_DEPTH
) (
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    input  wire pbum_sel_t             fn_sel,
    input  wire logic                  scc_eth_mode,
    input  wire pbum_tx_t              tx_word,
    input  wire logic                  tx_valid,
    output logic                       tx_ready,
    input  wire logic                  tx_tick,
    input  wire logic                  fcc_rts_req,
    input  wire logic                  fcc_cts_n,
    output logic                       fcc_grant,
    input  wire logic                  scc_rts_req,
    input  wire logic                  scc_cts_n,
    output logic                       scc_grant,
    input  wire logic                  scc_scc_ethernet_tx_enable,
    output pbum_rx_t                   rx_word,
    output logic                       mii_broken_hdr,
    input  wire logic [PBUM_NPINS-1:0] pin_in,
    output logic      [PBUM_NPINS-1:0] pin_out,
    output logic      [PBUM_NPINS-1:0] pin_oe_n
);

    // Direction of each pin's selected function; off or unknown is input
    function automatic logic pin_is_out(input int idx, input pbum_fn_t fn,
                                        input logic eth);
        logic o;
        o = 1'h0;
        case (idx)
            IDX_B31: o = (fn == FN_FCC_MII) || (fn == FN_TDM);
            IDX_B30: o = (fn == FN_SCC);
            IDX_B29: o = (fn == FN_FCC_MII);
            IDX_B28: o = (fn == FN_FCC_HDLC) || (fn == FN_SCC);
            IDX_B27: o = (fn == FN_TDM);
            default: o = 1'h0;
        endcase
        return o;
    endfunction

    function automatic pbum_fn_t fn_of(input int idx, input pbum_sel_t s);
        pbum_fn_t f;
        f = FN_OFF;
        case (idx)
            IDX_B31: f = s.b31;
            IDX_B30: f = s.b30;
            IDX_B29: f = s.b29;
            IDX_B28: f = s.b28;
            IDX_B27: f = s.b27;
            default: f = s.b26;
        endcase
        return f;
    endfunction

    // Transmit path: FIFO drained one word per tick
    pbum_tx_t fifo_out;
    logic     fifo_valid;
    logic     fifo_pop;
    pbum_tx_t txw_q, txw_d;

    pbum_fifo #(
        .WIDTH (PBUM_TX_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .in_data   (tx_word),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    assign fifo_pop = tx_tick;

    // Underrun on a tick drops TX_EN, so it never marks stale data
    always_comb begin
        txw_d = txw_q;
        if (tx_tick) begin
            txw_d = fifo_valid ? fifo_out : TX_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            txw_q <= TX_IDLE;
        end else begin
            txw_q <= txw_d;
        end
    end

    // Request-to-send handshakes for both controllers
    logic [1:0]   rts_req;
    logic [1:0]   cts_n;
    logic [1:0]   rts_n;
    logic [1:0]   grant_q;
    logic [1:0]   grant_d;
    pbum_rts_st_t rts_st_q [2];
    pbum_rts_st_t rts_st_d [2];

    assign rts_req[RTS_FCC] = fcc_rts_req;
    assign rts_req[RTS_SCC] = scc_rts_req;
    assign cts_n[RTS_FCC]   = fcc_cts_n;
    assign cts_n[RTS_SCC]   = scc_cts_n;

    genvar r;
    generate
        for (r = 0; r < 2; r++) begin : g_rts
            // RTS runs independent of data timing
            always_comb begin
                rts_st_d[r] = rts_st_q[r];
                case (rts_st_q[r])
                    RS_IDLE: begin
                        if (rts_req[r]) begin
                            rts_st_d[r] = RS_REQ;
                        end
                    end
                    RS_REQ: begin
                        if (!rts_req[r]) begin
                            rts_st_d[r] = RS_IDLE;
                        end else if (!cts_n[r]) begin
                            rts_st_d[r] = RS_GRANT;
                        end
                    end
                    RS_GRANT: begin
                        if (!rts_req[r]) begin
                            rts_st_d[r] = RS_IDLE;
                        end
                    end
                    default: rts_st_d[r] = RS_IDLE;
                endcase
                grant_d[r] = (rts_st_d[r] == RS_GRANT);
                rts_n[r]   = (rts_st_q[r] == RS_IDLE);
            end

            always_ff @(posedge clk_sys) begin
                if (!nrst) begin
                    rts_st_q[r] <= RS_IDLE;
                    grant_q[r]  <= 1'h0;
                end else begin
                    rts_st_q[r] <= rts_st_d[r];
                    grant_q[r]  <= grant_d[r];
                end
            end
        end
    endgenerate

    assign fcc_grant = grant_q[RTS_FCC];
    assign scc_grant = grant_q[RTS_SCC];

    // Drive value per pin from the selected output function
    logic [PBUM_NPINS-1:0] drv_val;
    logic [PBUM_NPINS-1:0] drv_en;
    logic [PBUM_NPINS-1:0] pin_val;
    logic                  scc_b28;

    // Ethernet mode turns the serial RTS pin into transmit enable
    assign scc_b28 = scc_eth_mode ? scc_scc_ethernet_tx_enable : rts_n[RTS_SCC];

    always_comb begin
        drv_val = '0;
        case (fn_sel.b31)
            FN_FCC_MII: drv_val[IDX_B31] = txw_q.mii_tx_er;
            FN_TDM:     drv_val[IDX_B31] = txw_q.l1_txd_b;
            default:    drv_val[IDX_B31] = 1'h0;
        endcase
        case (fn_sel.b30)
            FN_SCC:     drv_val[IDX_B30] = txw_q.scc_txd;
            default:    drv_val[IDX_B30] = 1'h0;
        endcase
        case (fn_sel.b29)
            FN_FCC_MII: drv_val[IDX_B29] = txw_q.mii_tx_en;
            default:    drv_val[IDX_B29] = 1'h0;
        endcase
        case (fn_sel.b28)
            FN_FCC_HDLC: drv_val[IDX_B28] = rts_n[RTS_FCC];
            FN_SCC:      drv_val[IDX_B28] = scc_b28;
            default:     drv_val[IDX_B28] = 1'h0;
        endcase
        case (fn_sel.b27)
            FN_TDM:     drv_val[IDX_B27] = txw_q.l1_txd_c;
            default:    drv_val[IDX_B27] = 1'h0;
        endcase
    end

    genvar p;
    generate
        for (p = 0; p < PBUM_NPINS; p++) begin : g_pin
            // Only an output function may enable the buffer
            assign drv_en[p] = pin_is_out(p, fn_of(p, fn_sel),
                                          scc_eth_mode);

            pbum_pad u_pad (
                .clk_sys   (clk_sys),
                .nrst      (nrst),
                .drive_en  (drv_en[p]),
                .drive_val (drv_val[p]),
                .pin_in    (pin_in[p]),
                .pin_out   (pin_out[p]),
                .pin_oe_n  (pin_oe_n[p]),
                .pin_val   (pin_val[p])
            );
        end
    endgenerate

    // Receive side: each input reaches only its selected peripheral
    pbum_rx_t rx_q, rx_d;
    logic     hdr_q, hdr_d;

    always_comb begin
        rx_d = RX_IDLE;
        if (fn_sel.b31 == FN_SCC) begin
            rx_d.scc_rxd = pin_val[IDX_B31];
        end
        if (fn_sel.b30 == FN_FCC_MII) begin
            rx_d.mii_rx_dv = pin_val[IDX_B30];
        end
        if (fn_sel.b30 == FN_TDM) begin
            rx_d.l1_rxd_b = pin_val[IDX_B30];
        end
        if (fn_sel.b29 == FN_TDM) begin
            rx_d.l1_rsync_b = pin_val[IDX_B29];
        end
        if (fn_sel.b28 == FN_FCC_MII) begin
            rx_d.mii_rx_er = pin_val[IDX_B28];
        end
        if (fn_sel.b28 == FN_TDM) begin
            rx_d.l1_tsync_b = pin_val[IDX_B28];
        end
        if (fn_sel.b27 == FN_FCC_MII) begin
            rx_d.mii_col = pin_val[IDX_B27];
        end
        if (fn_sel.b26 == FN_FCC_MII) begin
            rx_d.mii_crs = pin_val[IDX_B26];
        end
        if (fn_sel.b26 == FN_TDM) begin
            rx_d.l1_rxd_c = pin_val[IDX_B26];
        end
        // Carrier without valid data is a damaged header, not frame data
        hdr_d = rx_d.mii_crs && !rx_d.mii_rx_dv;
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rx_q  <= RX_IDLE;
            hdr_q <= 1'h0;
        end else begin
            rx_q  <= rx_d;
            hdr_q <= hdr_d;
        end
    end

    assign rx_word        = rx_q;
    assign mii_broken_hdr = hdr_q;

endmodule

// file: pbum_asserts.sv
// Checker for the port B upper pin multiplexer.
// Assumes binding onto pbum_top; sees only its ports.
`timescale 1ns/1ns
module pbum_asserts
    import pbum_pkg::*;
#(
    parameter int FIFO_DEPTH = PBUM_FIFO_DEPTH
) (
    input wire logic                  clk_sys,
    input wire logic                  nrst,
    input wire pbum_sel_t             fn_sel,
    input wire logic                  scc_eth_mode,
    input wire pbum_tx_t              tx_word,
    input wire logic                  tx_valid,
    input wire logic                  tx_ready,
    input wire logic                  tx_tick,
    input wire logic                  fcc_rts_req,
    input wire logic                  fcc_cts_n,
    input wire logic                  fcc_grant,
    input wire logic                  scc_rts_req,
    input wire logic                  scc_cts_n,
    input wire logic                  scc_grant,
    input wire logic                  scc_scc_ethernet_tx_enable,
    input wire pbum_rx_t              rx_word,
    input wire logic                  mii_broken_hdr,
    input wire logic [PBUM_NPINS-1:0] pin_in,
    input wire logic [PBUM_NPINS-1:0] pin_out,
    input wire logic [PBUM_NPINS-1:0] pin_oe_n
);
    int cnt_q;
    int cnt_d;

    // Shadow word count, so fullness is judged without the FIFO's own flops
    always_comb begin
        cnt_d = cnt_q + int'(tx_valid && tx_ready) - int'(tx_tick && cnt_q != 0);
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cnt_q <= 0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_b26_never_driven: assert property (pin_oe_n[IDX_B26])
        else $error("bit 26 pin driven");
    a_b30_input_mode: assert property (fn_sel.b30 != FN_SCC |=> pin_oe_n[IDX_B30])
        else $error("bit 30 driven without output function");
    a_b27_tdm_drive: assert property (fn_sel.b27 == FN_TDM |=> !pin_oe_n[IDX_B27])
        else $error("bit 27 not driven under channel C2");
    a_unsel_rxd_idle: assert property (fn_sel.b31 != FN_SCC |=> rx_word.scc_rxd)
        else $error("unselected serial rxd not idle");
    a_crs_route_two: assert property ((fn_sel.b26 == FN_FCC_MII) [*3]
        |-> rx_word.mii_crs == $past(pin_in[IDX_B26], 2))
        else $error("carrier sense not routed");
    a_broken_hdr_flag: assert property (
        (fn_sel.b26 == FN_FCC_MII && fn_sel.b30 == FN_FCC_MII) [*3]
        |-> mii_broken_hdr == ($past(pin_in[IDX_B26], 2) && !$past(pin_in[IDX_B30], 2)))
        else $error("broken header flag wrong");
    a_fifo_ready_count: assert property (tx_ready == (cnt_q < FIFO_DEPTH))
        else $error("tx_ready disagrees with word count");
    a_txen_underrun: assert property (
        (fn_sel.b29 == FN_FCC_MII && tx_tick && cnt_q == 0) ##1
        (fn_sel.b29 == FN_FCC_MII) |=> !pin_out[IDX_B29] && !pin_oe_n[IDX_B29])
        else $error("TX_EN high with no data");
    a_rts_fcc_low: assert property ((fn_sel.b28 == FN_FCC_HDLC && fcc_rts_req) [*3]
        |-> !pin_oe_n[IDX_B28] && !pin_out[IDX_B28])
        else $error("fast controller RTS not low");
    // Pin lags the dropped request by state flop plus pad flop
    a_rts_fcc_idle: assert property ((fn_sel.b28 == FN_FCC_HDLC && !fcc_rts_req) [*3]
        |-> pin_out[IDX_B28])
        else $error("fast controller RTS low without request");
    a_grant_needs_cts: assert property (
        $rose(fcc_grant) |-> !$past(fcc_cts_n) && $past(fcc_rts_req))
        else $error("grant without CTS");
    a_scc_grant_drop: assert property (!scc_rts_req |=> !scc_grant)
        else $error("serial grant held without request");

    c_fcc_grant: cover property (fcc_grant);
    c_scc_grant: cover property (scc_grant);
    c_broken_hdr: cover property (mii_broken_hdr);
    c_fifo_full: cover property (!tx_ready);
endmodule

bind pbum_top pbum_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_pbum_asserts (
    .clk_sys(clk_sys), .nrst(nrst), .fn_sel(fn_sel), .scc_eth_mode(scc_eth_mode),
    .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_tick(tx_tick),
    .fcc_rts_req(fcc_rts_req), .fcc_cts_n(fcc_cts_n), .fcc_grant(fcc_grant),
    .scc_rts_req(scc_rts_req), .scc_cts_n(scc_cts_n), .scc_grant(scc_grant),
    .scc_scc_ethernet_tx_enable(scc_scc_ethernet_tx_enable), .rx_word(rx_word), .mii_broken_hdr(mii_broken_hdr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n)
);

// file: pbum_partner.sv
// Far-side peers: PHY, serial modem peer and TDM highway on six pins.
// Assumes far_val is set by the bench; CTS follows RTS after cts_wait.
`timescale 1ns/1ns
module pbum_partner
    import pbum_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe_n,
    input  wire logic [5:0] far_val,
    input  wire pbum_fn_t   rts_fn,
    input  wire logic [3:0] cts_wait,
    output logic      [5:0] pin_in,
    output logic            fcc_cts_n,
    output logic            scc_cts_n
);
    logic [3:0] wait_q;
    logic       rts_low;

    // Driven pins read back; the others carry the peer levels
    assign pin_in = (~pin_oe_n & pin_out)
                  | (pin_oe_n & far_val);
    assign rts_low = !pin_oe_n[IDX_B28] && !pin_out[IDX_B28];

    always_ff @(posedge clk_sys) begin
        if (!nrst || !rts_low) begin
            wait_q <= 4'h0;
        end else if (wait_q != 4'hf) begin
            wait_q <= wait_q + 4'h1;
        end
    end

    // Slow peers hold CTS off for a while, testing the wait in REQ
    assign fcc_cts_n = !(rts_low && rts_fn == FN_FCC_HDLC && wait_q >= cts_wait);
    assign scc_cts_n = !(rts_low && rts_fn == FN_SCC && wait_q >= cts_wait);
endmodule

// file: tb.sv
// Self-checking bench for pbum_top with its far-side partner.
// Assumes the pbum_asserts bind is compiled alongside.
`timescale 1ns/1ns
module tb;
    import pbum_pkg::*;
    logic       clk_sys, nrst, scc_eth_mode, tx_valid, tx_ready, tx_tick;
    logic       fcc_rts_req, fcc_cts_n, fcc_grant, scc_rts_req, scc_cts_n, scc_grant;
    logic       scc_scc_ethernet_tx_enable, mii_broken_hdr;
    logic [5:0] pin_in, pin_out, pin_oe_n, far_val;
    logic [3:0] cts_wait;
    pbum_sel_t  fn_sel;
    pbum_tx_t   tx_word, cur;
    pbum_rx_t   rx_word, er;
    pbum_tx_t   q[$];
    logic [11:0] ep;
    int         seed = 74;
    int         bad_count = 0;
    int         n_tests = 0;

    pbum_top u_pbum_top (.clk_sys(clk_sys), .nrst(nrst), .fn_sel(fn_sel),
        .scc_eth_mode(scc_eth_mode), .tx_word(tx_word), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_tick(tx_tick), .fcc_rts_req(fcc_rts_req),
        .fcc_cts_n(fcc_cts_n), .fcc_grant(fcc_grant), .scc_rts_req(scc_rts_req),
        .scc_cts_n(scc_cts_n), .scc_grant(scc_grant), .scc_scc_ethernet_tx_enable(scc_scc_ethernet_tx_enable),
        .rx_word(rx_word), .mii_broken_hdr(mii_broken_hdr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    pbum_partner u_pbum_partner (.clk_sys(clk_sys), .nrst(nrst), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .far_val(far_val), .rts_fn(fn_sel.b28), .cts_wait(cts_wait),
        .pin_in(pin_in), .fcc_cts_n(fcc_cts_n), .scc_cts_n(scc_cts_n));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Expected {oe_n, out}; RTS lines idle high since requests stay low here
    function automatic logic [11:0] exp_pins(pbum_sel_t s, pbum_tx_t w, logic e, logic t);
        logic [5:0] d, v;
        d = {s.b31 inside {FN_FCC_MII, FN_TDM}, s.b30 == FN_SCC, s.b29 == FN_FCC_MII,
             s.b28 inside {FN_FCC_HDLC, FN_SCC}, s.b27 == FN_TDM, 1'b0};
        v[5] = s.b31 == FN_TDM ? w.l1_txd_b : d[5] & w.mii_tx_er;
        v[4] = d[4] & w.scc_txd;
        v[3] = d[3] & w.mii_tx_en;
        v[2] = (s.b28 == FN_SCC && e) ? t : d[2];
        v[1] = d[1] & w.l1_txd_c;
        v[0] = 1'b0;
        return {~d, v};
    endfunction

    function automatic pbum_rx_t exp_rx(pbum_sel_t s, logic [5:0] p);
        pbum_rx_t r;
        r = RX_IDLE;
        r.scc_rxd = s.b31 == FN_SCC ? p[5] : 1'b1;
        r.mii_rx_dv = s.b30 == FN_FCC_MII && p[4];
        r.l1_rxd_b = s.b30 == FN_TDM ? p[4] : 1'b1;
        r.l1_rsync_b = s.b29 == FN_TDM && p[3];
        r.mii_rx_er = s.b28 == FN_FCC_MII && p[2];
        r.l1_tsync_b = s.b28 == FN_TDM && p[2];
        r.mii_col = s.b27 == FN_FCC_MII && p[1];
        r.mii_crs = s.b26 == FN_FCC_MII && p[0];
        r.l1_rxd_c = s.b26 == FN_TDM ? p[0] : 1'b1;
        return r;
    endfunction

    initial begin
        #(2000 * 50);
        bad_count++;
        finish_test();
    end

    initial begin
        nrst = 1'b0;
        fn_sel = '{default: FN_OFF};
        {scc_eth_mode, tx_valid, tx_tick, fcc_rts_req, scc_rts_req, scc_scc_ethernet_tx_enable} = '0;
        tx_word = TX_IDLE;
        far_val = 6'h00;
        cts_wait = 4'h0;
        cur = TX_IDLE;
        repeat (10) step();
        nrst = 1'b1;
        chk({pin_oe_n, pin_out}, 12'hfc0);
        chk(rx_word, RX_IDLE);
        chk({tx_ready, fcc_grant, scc_grant, mii_broken_hdr}, 4'h8);
        // Random selections, including unused codes, against the routing model
        for (int i = 0; i < 40; i++) begin
            // First pass forces carrier without data valid on both MII pins
            fn_sel = (i == 0) ? pbum_sel_t'{b31: FN_OFF, b30: FN_FCC_MII, b29: FN_OFF,
                                            b28: FN_OFF, b27: FN_OFF, b26: FN_FCC_MII}
                              : pbum_sel_t'(18'($random(seed)));
            {scc_eth_mode, scc_scc_ethernet_tx_enable, far_val} = (i == 0) ? 8'h01 : 8'($random(seed));
            repeat (3) step();
            ep = exp_pins(fn_sel, cur, scc_eth_mode, scc_scc_ethernet_tx_enable);
            er = exp_rx(fn_sel, (~ep[11:6] & ep[5:0]) | (ep[11:6] & far_val));
            chk({pin_oe_n, pin_out}, ep);
            chk(rx_word, er);
            chk(mii_broken_hdr, er.mii_crs && !er.mii_rx_dv);
        end
        // Fill the FIFO past full, then drain with one underrun tick
        for (int pass = 0; pass < 2; pass++) begin
            fn_sel = '{b31: pass ? FN_TDM : FN_FCC_MII, b30: FN_SCC, b29: FN_FCC_MII,
                       b28: FN_OFF, b27: FN_TDM, b26: FN_OFF};
            scc_eth_mode = 1'b0;
            for (int k = 0; k < 5; k++) begin
                tx_word = pbum_tx_t'(5'($random(seed)));
                tx_valid = 1'b1;
                if (q.size() < 4) q.push_back(tx_word);
                step();
                chk(tx_ready, q.size() < 4);
            end
            tx_valid = 1'b0;
            for (int k = 0; k < 5; k++) begin
                tx_tick = 1'b1;
                cur = q.size() ? q.pop_front() : TX_IDLE;
                step();
                tx_tick = 1'b0;
                step();
                ep = exp_pins(fn_sel, cur, 1'b0, 1'b0);
                chk({pin_oe_n, pin_out}, ep);
            end
        end
        // Request to send on both controllers; the serial peer answers slowly
        for (int c = 0; c < 2; c++) begin
            fn_sel = '{default: FN_OFF};
            fn_sel.b28 = c ? FN_SCC : FN_FCC_HDLC;
            cts_wait = c ? 4'h6 : 4'h0;
            repeat (2) step();
            {scc_rts_req, fcc_rts_req} = c ? 2'b10 : 2'b01;
            for (int k = 0; k < 20 && !(c ? scc_grant : fcc_grant); k++) step();
            chk(c ? scc_grant : fcc_grant, 1'b1);
            chk({pin_oe_n[2], pin_out[2]}, 2'b00);
            {scc_rts_req, fcc_rts_req} = 2'b00;
            repeat (2) step();
            chk({fcc_grant, scc_grant, pin_out[2]}, 3'b001);
        end
        finish_test();
    end
endmodule
